// ==== core/meter_alarm_scaling_colour_ctrl.sv ====
// panel meter relay reaction, range, user curve, warning and display colour logic
`timescale 1ns/100ps
module meter_alarm_scaling_colour_ctrl #(
	parameter int unsigned TICK_CYC = meter_pkg::TICK_CYC,
	parameter int unsigned MAX_POINTS = meter_pkg::MAX_POINTS
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// measurement front end
	input wire logic signed [19:0] input_uv,
	input wire logic signed [19:0] result_value,
	input wire logic [1:0] relay_raw,
	input wire logic frame_rx,
	// front keys up, down, enter, esc
	input wire logic [3:0] keys,
	// relay, alarm and display
	output logic [1:0] relay_out,
	output logic alarm_out,
	output logic colour_red,
	output logic colour_green,
	output meter_pkg::disp_t disp_sel,
	output logic signed [15:0] disp_value,
	output logic [1:0] dec_point,
	output logic [2:0] filter_level,
	output logic [1:0] input_range,
	output meter_pkg::char_t charact
);
	localparam int unsigned DW = $clog2(TICK_CYC);
	localparam logic [10:0] SHOW_T = 11'(meter_pkg::SHOW_COUNT_MS / meter_pkg::TICK_MS);
	localparam logic [10:0] HOLD_T = 11'(meter_pkg::HOLD_MS / meter_pkg::TICK_MS);
	localparam logic [9:0] SEC_T = 10'(meter_pkg::SEC_MS / meter_pkg::TICK_MS);

	// bus
	logic wr_ff;
	logic [7:0] addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rd_mux;
	wire acc = hsel && htrans[1] && hready;
	wire mapped = haddr[31:8] == 24'h00_0000;
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ff <= 1'b0;
			addr_ff <= 8'h00;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			wr_ff <= acc && hwrite && mapped;
			addr_ff <= haddr[7:0];
			if (acc && !hwrite) begin
				hrdata_ff <= mapped ? rd_mux : 32'h0000_0000;
			end
		end
	end
	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// configuration registers
	meter_pkg::ctrl_t ctrl_ff;
	logic signed [15:0] lo_ff, hi_ff, th_ff, curve_lo, curve_hi, lo_x, hi_x;
	logic [7:0] pct_ff;
	logic [6:0] tmo_ff;
	logic [9:0] hy_ff;
	meter_pkg::point_t stage_ff;
	meter_pkg::point_t pts_ff [MAX_POINTS];
	logic [4:0] cnt_ff, sel_ff, nxt_sel;
	logic err_ff, dup, show_y_ff, nxt_y, del_mode_ff, del_go;
	meter_pkg::ctrl_t wctrl;
	assign wctrl = meter_pkg::ctrl_t'(hwdata);
	wire user = ctrl_ff.charact == meter_pkg::CH_USER;
	wire signed [15:0] wlo = hwdata[15:0];
	wire signed [15:0] whi = hwdata[31:16];
	wire ctrl_ok = wctrl.filter_level <= 3'(meter_pkg::FILTER_LEVEL_MAX) && wctrl.mode1 <= meter_pkg::RM_REMOTE &&
		wctrl.mode2 <= meter_pkg::RM_REMOTE && wctrl.critical_reaction1 <= meter_pkg::CR_OFF &&
		wctrl.critical_reaction2 <= meter_pkg::CR_OFF;
	wire pair_ok = meter_pkg::in_disp(20'(wlo)) && meter_pkg::in_disp(20'(whi));
	wire pt_ok = wlo >= meter_pkg::X_MIN && wlo <= meter_pkg::X_MAX && meter_pkg::in_disp(20'(whi));
	wire lim_ok = hwdata[7:0] <= 8'(meter_pkg::PCT_MAX) && hwdata[14:8] <= 7'(meter_pkg::TMO_MAX);
	wire col_ok = meter_pkg::in_disp(20'(wlo)) && hwdata[25:16] <= 10'(meter_pkg::HYSTERESIS_VALUE_MAX);
	wire w_ctrl = wr_ff && addr_ff == meter_pkg::REG_CTRL && ctrl_ok;
	wire w_scale = wr_ff && addr_ff == meter_pkg::REG_SCALE && pair_ok && !user;
	wire w_limit = wr_ff && addr_ff == meter_pkg::REG_LIMIT && lim_ok;
	wire w_colth = wr_ff && addr_ff == meter_pkg::REG_COLTH && col_ok;
	wire w_point = wr_ff && addr_ff == meter_pkg::REG_POINT;
	wire w_cmd = wr_ff && addr_ff == meter_pkg::REG_CMD && user;
	wire w_errclr = wr_ff && addr_ff == meter_pkg::REG_STAT && hwdata[meter_pkg::STAT_ERR_BIT];
	wire op_add = w_cmd && hwdata[1:0] == meter_pkg::OP_ADD;
	meter_pkg::ui_t ui_ff, nxt_ui;
	wire brw_go = w_cmd && hwdata[1] && ui_ff == meter_pkg::UI_IDLE;
	wire edit_on = ui_ff == meter_pkg::UI_EDIT;
	wire add_go = op_add && !dup && (edit_on || cnt_ff < 5'(MAX_POINTS));
	wire err_set = (op_add && !add_go) || (w_point && !pt_ok);
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_ff <= meter_pkg::ctrl_t'(meter_pkg::CTRL_RST);
			lo_ff <= 16'h0000;
			hi_ff <= 16'h0000;
			pct_ff <= 8'h00;
			tmo_ff <= 7'h00;
			th_ff <= 16'h0000;
			hy_ff <= 10'h000;
			stage_ff <= 32'h0000_0000;
			err_ff <= 1'b0;
			del_mode_ff <= 1'b0;
		end else begin
			if (w_ctrl) ctrl_ff <= {4'h0, hwdata[27:0]};
			if (w_scale) lo_ff <= wlo;
			if (w_scale) hi_ff <= whi;
			if (w_limit) pct_ff <= hwdata[7:0];
			if (w_limit) tmo_ff <= hwdata[14:8];
			if (w_colth) th_ff <= wlo;
			if (w_colth) hy_ff <= hwdata[25:16];
			if (w_point && pt_ok) stage_ff <= hwdata;
			err_ff <= err_set || (err_ff && !w_errclr);
			if (brw_go) del_mode_ff <= hwdata[1:0] == meter_pkg::OP_DEL;
		end
	end

	// user curve points; deletion shifts the tail down to keep the table packed
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff <= 5'h00;
			for (int i = 0; i < MAX_POINTS; i++) pts_ff[i] <= 32'h0000_0000;
		end else if (add_go) begin
			if (edit_on) pts_ff[sel_ff] <= stage_ff;
			else pts_ff[cnt_ff] <= stage_ff;
			if (!edit_on) cnt_ff <= cnt_ff + 5'h01;
		end else if (del_go) begin
			for (int i = 0; i < MAX_POINTS - 1; i++) begin
				if (5'(i) >= sel_ff) pts_ff[i] <= pts_ff[i + 1];
			end
			cnt_ff <= cnt_ff - 5'h01;
		end
	end
	always_comb begin
		dup = 1'b0;
		curve_lo = 16'h0000;
		curve_hi = 16'h0000;
		lo_x = 16'h0000;
		hi_x = 16'h0000;
		for (int i = 0; i < MAX_POINTS; i++) begin
			if (5'(i) < cnt_ff && !(edit_on && 5'(i) == sel_ff) && pts_ff[i].x == stage_ff.x) dup = 1'b1;
		end
		for (int i = 0; i < MAX_POINTS; i++) begin
			// table is unsorted: track running extremes of x
			if (5'(i) < cnt_ff && (i == 0 || pts_ff[i].x < lo_x)) begin
				lo_x = pts_ff[i].x;
				curve_lo = pts_ff[i].y;
			end
			if (5'(i) < cnt_ff && (i == 0 || pts_ff[i].x > hi_x)) begin
				hi_x = pts_ff[i].x;
				curve_hi = pts_ff[i].y;
			end
		end
	end

	// millisecond tick and communication supervision
	logic [DW-1:0] div_ff;
	logic [9:0] ms_ff;
	logic [6:0] secs_ff;
	wire tick = div_ff == DW'(TICK_CYC - 1);
	wire sec_p = tick && ms_ff == SEC_T - 10'h001;
	always_ff @(posedge clk) begin
		if (srst) begin
			div_ff <= '0;
			ms_ff <= 10'h000;
			secs_ff <= 7'h00;
		end else begin
			div_ff <= tick ? '0 : div_ff + 1'b1;
			if (frame_rx) ms_ff <= 10'h000;
			else if (tick) ms_ff <= sec_p ? 10'h000 : ms_ff + 10'h001;
			if (frame_rx) secs_ff <= 7'h00;
			else if (sec_p && secs_ff != 7'h7F) secs_ff <= secs_ff + 7'h01;
		end
	end
	wire comm_lost = tmo_ff != 7'h00 && secs_ff > tmo_ff;

	// permissible range, compared scaled up to avoid a divider
	wire signed [31:0] in_scaled = 32'(input_uv) * 32'sd1000;
	wire [31:0] border = meter_pkg::full_scale_uv(ctrl_ff.input_range) * (32'(meter_pkg::PCT_SCALE) + 32'(pct_ff));
	wire under = input_uv < 20'sd0;
	wire over = in_scaled > $signed(border);
	wire oor = under || over;

	// relays
	function automatic logic relay_next(input meter_pkg::rmode_t m, input meter_pkg::crit_t cr, input logic crit,
		input logic raw, input logic rem, input logic prev);
		logic r;
		if (crit && cr == meter_pkg::CR_ON) r = 1'b1;
		else if (crit && cr == meter_pkg::CR_OFF) r = 1'b0;
		else if (crit) r = prev;
		else if (m == meter_pkg::RM_DISABLED) r = 1'b0;
		else if (m == meter_pkg::RM_REMOTE) r = rem;
		else r = raw;
		return r;
	endfunction
	logic [1:0] relay_ff;
	wire crit1 = (ctrl_ff.mode1 == meter_pkg::RM_REMOTE) ? comm_lost : oor;
	wire crit2 = (ctrl_ff.mode2 == meter_pkg::RM_REMOTE) ? comm_lost : oor;
	always_ff @(posedge clk) begin
		if (srst) relay_ff <= 2'b00;
		else relay_ff <= {relay_next(ctrl_ff.mode2, ctrl_ff.critical_reaction2, crit2, relay_raw[1],
			ctrl_ff.remote_state[1], relay_ff[1]), relay_next(ctrl_ff.mode1, ctrl_ff.critical_reaction1,
			crit1, relay_raw[0], ctrl_ff.remote_state[0], relay_ff[0])};
	end

	// keys are pins: two stages before use
	logic [3:0] ks1_ff, ks2_ff, kp_ff;
	logic [10:0] hold_ff, tmr_ff;
	always_ff @(posedge clk) begin
		if (srst) begin
			ks1_ff <= 4'h0;
			ks2_ff <= 4'h0;
			kp_ff <= 4'h0;
			hold_ff <= 11'h000;
		end else begin
			ks1_ff <= keys;
			ks2_ff <= ks1_ff;
			kp_ff <= ks2_ff;
			if (!ks2_ff[2]) hold_ff <= 11'h000;
			else if (tick && hold_ff != HOLD_T) hold_ff <= hold_ff + 11'h001;
		end
	end
	wire [3:0] krise = ks2_ff & ~kp_ff;
	wire long_p = ks2_ff[2] && tick && hold_ff == HOLD_T - 11'h001;
	wire short_p = !ks2_ff[2] && kp_ff[2] && hold_ff < HOLD_T;

	// point browse for delete and edit
	always_comb begin
		nxt_ui = ui_ff;
		nxt_sel = sel_ff;
		nxt_y = show_y_ff;
		del_go = 1'b0;
		case (ui_ff)
			meter_pkg::UI_IDLE: begin
				if (brw_go) begin
					nxt_ui = meter_pkg::UI_COUNT;
					nxt_sel = 5'h00;
					nxt_y = 1'b0;
				end
			end
			meter_pkg::UI_COUNT: begin
				if (tick && tmr_ff == SHOW_T - 11'h001) begin
					nxt_ui = (cnt_ff == 5'h00) ? meter_pkg::UI_IDLE : meter_pkg::UI_SELECT;
				end
			end
			meter_pkg::UI_SELECT: begin
				if (krise[3]) nxt_ui = meter_pkg::UI_IDLE;
				else if (long_p) nxt_ui = del_mode_ff ? meter_pkg::UI_ASK : meter_pkg::UI_EDIT;
				else if (short_p) nxt_y = !show_y_ff;
				else if (krise[0]) nxt_sel = (sel_ff == cnt_ff - 5'h01) ? 5'h00 : sel_ff + 5'h01;
				else if (krise[1]) nxt_sel = (sel_ff == 5'h00) ? cnt_ff - 5'h01 : sel_ff - 5'h01;
			end
			meter_pkg::UI_ASK: begin
				if (krise[2]) begin
					del_go = 1'b1;
					nxt_ui = meter_pkg::UI_COUNT;
					nxt_sel = 5'h00;
				end else if (krise[3]) begin
					nxt_ui = meter_pkg::UI_SELECT;
				end
			end
			meter_pkg::UI_EDIT: begin
				if (add_go || krise[3]) nxt_ui = meter_pkg::UI_SELECT;
			end
			default: begin
				nxt_ui = meter_pkg::UI_IDLE;
			end
		endcase
		if (!user) nxt_ui = meter_pkg::UI_IDLE;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			ui_ff <= meter_pkg::UI_IDLE;
			sel_ff <= 5'h00;
			show_y_ff <= 1'b0;
			tmr_ff <= 11'h000;
		end else begin
			ui_ff <= nxt_ui;
			sel_ff <= nxt_sel;
			show_y_ff <= nxt_y;
			tmr_ff <= (nxt_ui != meter_pkg::UI_COUNT || ui_ff != nxt_ui) ? 11'h000 : tmr_ff + 11'(tick);
		end
	end

	// colour threshold with hysteresis and sticky colour events
	logic thr_ff, red_ff, alarm_ff;
	logic [3:0] ev_ff, src_q_ff;
	wire signed [20:0] up_b = 21'(th_ff) + 21'(hy_ff);
	wire signed [20:0] dn_b = 21'(th_ff) - 21'(hy_ff);
	wire above = 21'(result_value) > up_b;
	wire below = 21'(result_value) < dn_b;
	wire [3:0] src = {thr_ff, oor, relay_ff};
	wire [3:0] en = {ctrl_ff.extra_threshold_colour_enable, ctrl_ff.alarm_colour_enable,
		ctrl_ff.relay2_colour_enable, ctrl_ff.relay1_colour_enable};
	wire [3:0] ev_rise = src & ~src_q_ff & en;
	wire ack = ctrl_ff.colour_ack_enable && |krise;
	always_ff @(posedge clk) begin
		if (srst) begin
			thr_ff <= 1'b0;
			ev_ff <= 4'h0;
			src_q_ff <= 4'h0;
			red_ff <= 1'b0;
			alarm_ff <= 1'b0;
		end else begin
			if (ctrl_ff.falling_direction ? below : above) thr_ff <= 1'b1;
			else if (ctrl_ff.falling_direction ? above : below) thr_ff <= 1'b0;
			src_q_ff <= src;
			ev_ff <= (ev_ff & ~{4{ack}}) | ev_rise;
			red_ff <= ctrl_ff.base_colour_select ^ (|ev_ff);
			alarm_ff <= oor;
		end
	end

	// display selection
	meter_pkg::disp_t ds_ff, nxt_ds;
	logic signed [15:0] dv_ff, nxt_dv;
	always_comb begin
		nxt_dv = result_value[15:0];
		if (ui_ff == meter_pkg::UI_COUNT) nxt_ds = meter_pkg::DS_COUNT;
		else if (ui_ff == meter_pkg::UI_ASK) nxt_ds = meter_pkg::DS_ASK;
		else if (ui_ff != meter_pkg::UI_IDLE) nxt_ds = meter_pkg::DS_POINT;
		else if (err_ff) nxt_ds = meter_pkg::DS_ERR;
		else if (under) nxt_ds = meter_pkg::DS_UNDER;
		else if (over) nxt_ds = meter_pkg::DS_OVER;
		else if (user && cnt_ff < 5'h02) nxt_ds = meter_pkg::DS_FEW;
		else if (!meter_pkg::in_disp(result_value)) nxt_ds = meter_pkg::DS_OVFL;
		else nxt_ds = meter_pkg::DS_NUMBER;
		if (ui_ff == meter_pkg::UI_COUNT) nxt_dv = 16'(cnt_ff);
		else if (nxt_ds == meter_pkg::DS_POINT) nxt_dv = show_y_ff ? pts_ff[sel_ff].y : pts_ff[sel_ff].x;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			ds_ff <= meter_pkg::DS_NUMBER;
			dv_ff <= 16'h0000;
		end else begin
			ds_ff <= nxt_ds;
			dv_ff <= nxt_dv;
		end
	end
	assign disp_sel = ds_ff;
	assign disp_value = dv_ff;
	assign relay_out = relay_ff;
	assign alarm_out = alarm_ff;
	assign colour_red = red_ff;
	assign colour_green = !red_ff;
	assign dec_point = ctrl_ff.dec_point;
	assign filter_level = ctrl_ff.filter_level;
	assign input_range = ctrl_ff.input_range;
	assign charact = ctrl_ff.charact;

	// register read
	always_comb begin
		if (haddr[7:0] == meter_pkg::REG_CTRL) rd_mux = ctrl_ff;
		else if (haddr[7:0] == meter_pkg::REG_SCALE) rd_mux = user ? {curve_hi, curve_lo} : {hi_ff, lo_ff};
		else if (haddr[7:0] == meter_pkg::REG_LIMIT) rd_mux = {17'h0, tmo_ff, pct_ff};
		else if (haddr[7:0] == meter_pkg::REG_COLTH) rd_mux = {6'h0, hy_ff, th_ff};
		else if (haddr[7:0] == meter_pkg::REG_POINT) rd_mux = stage_ff;
		else if (haddr[7:0] == meter_pkg::REG_STAT) rd_mux = {4'h0, ev_ff, show_y_ff, sel_ff, ui_ff, ds_ff,
			comm_lost, oor, relay_ff, red_ff, err_ff, cnt_ff};
		else rd_mux = 32'h0000_0000;
	end

	// checks
	sequence del_confirm_s;
		ui_ff == meter_pkg::UI_ASK && krise[2] && user;
	endsequence
	force_on_a: assert property (@(posedge clk) disable iff (srst)
		crit2 && ctrl_ff.critical_reaction2 == meter_pkg::CR_ON |=> relay_ff[1]) else $error("forced on failed");
	force_off_a: assert property (@(posedge clk) disable iff (srst)
		crit1 && ctrl_ff.critical_reaction1 == meter_pkg::CR_OFF |=> !relay_ff[0]) else $error("forced off failed");
	disabled_off_a: assert property (@(posedge clk) disable iff (srst)
		ctrl_ff.mode2 == meter_pkg::RM_DISABLED && !crit2 |=> !relay_ff[1]) else $error("disabled relay on");
	frame_clear_a: assert property (@(posedge clk) disable iff (srst)
		frame_rx |=> !comm_lost) else $error("timeout after frame");
	under_disp_a: assert property (@(posedge clk) disable iff (srst)
		under && ui_ff == meter_pkg::UI_IDLE && !err_ff |=> ds_ff == meter_pkg::DS_UNDER) else $error("no under");
	ovfl_disp_a: assert property (@(posedge clk) disable iff (srst)
		!oor && !user && !err_ff && ui_ff == meter_pkg::UI_IDLE && result_value > 20'sd9999
		|=> ds_ff == meter_pkg::DS_OVFL) else $error("no overflow warning");
	ack_clear_a: assert property (@(posedge clk) disable iff (srst)
		ack && ev_rise == 4'h0 |=> ev_ff == 4'h0 ##1 red_ff == ctrl_ff.base_colour_select) else $error("ack failed");
	colour_act_a: assert property (@(posedge clk) disable iff (srst)
		ev_ff != 4'h0 |=> red_ff == !$past(ctrl_ff.base_colour_select)) else $error("no active colour");
	scale_block_a: assert property (@(posedge clk) disable iff (srst)
		user |=> $stable(lo_ff) && $stable(hi_ff)) else $error("scale edited in user mode");
	dup_reject_a: assert property (@(posedge clk) disable iff (srst)
		op_add && dup |=> err_ff && $stable(cnt_ff)) else $error("duplicate point taken");
	delete_a: assert property (@(posedge clk) disable iff (srst)
		del_confirm_s |=> ui_ff == meter_pkg::UI_COUNT && cnt_ff == $past(cnt_ff) - 5'h01) else $error("delete failed");
endmodule

// ==== core/meter_pkg.sv ====
// constants, register map and types for the meter alarm, scaling and colour block
package meter_pkg;
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned SHOW_COUNT_MS = 1500;
	localparam int unsigned HOLD_MS = 2000;
	localparam int unsigned SEC_MS = 1000;
	localparam int unsigned MAX_POINTS = 20;
	localparam int DISP_MIN = -999;
	localparam int DISP_MAX = 9999;
	localparam int X_MIN = -999;
	localparam int X_MAX = 1999;
	localparam int unsigned PCT_MAX = 199;
	localparam int unsigned TMO_MAX = 99;
	localparam int unsigned HYSTERESIS_VALUE_MAX = 999;
	localparam int unsigned FILTER_LEVEL_MAX = 5;
	localparam int unsigned PCT_SCALE = 1000;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SCALE = 8'h04;
	localparam logic [7:0] REG_LIMIT = 8'h08;
	localparam logic [7:0] REG_COLTH = 8'h0C;
	localparam logic [7:0] REG_POINT = 8'h10;
	localparam logic [7:0] REG_CMD = 8'h14;
	localparam logic [7:0] REG_STAT = 8'h18;
	localparam int unsigned STAT_ERR_BIT = 5;
	localparam logic [1:0] OP_ADD = 2'h1;
	localparam logic [1:0] OP_DEL = 2'h2;
	localparam logic [1:0] OP_EDIT = 2'h3;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	typedef enum logic [2:0] {RM_DISABLED = 3'h0, RM_ON = 3'h1, RM_OFF = 3'h2, RM_IN = 3'h3, RM_OUT = 3'h4,
		RM_REMOTE = 3'h5} rmode_t;
	typedef enum logic [1:0] {CR_KEEP = 2'h0, CR_ON = 2'h1, CR_OFF = 2'h2} crit_t;
	typedef enum logic [1:0] {CH_LIN = 2'h0, CH_SQR = 2'h1, CH_SQRT = 2'h2, CH_USER = 2'h3} char_t;
	typedef enum logic [3:0] {DS_NUMBER = 4'h0, DS_UNDER = 4'h1, DS_OVER = 4'h2, DS_OVFL = 4'h3, DS_FEW = 4'h4,
		DS_ERR = 4'h5, DS_COUNT = 4'h6, DS_ASK = 4'h7, DS_POINT = 4'h8} disp_t;
	typedef enum logic [2:0] {UI_IDLE = 3'h0, UI_COUNT = 3'h1, UI_SELECT = 3'h2, UI_ASK = 3'h3,
		UI_EDIT = 3'h4} ui_t;
	typedef struct packed {
		logic [3:0] rsv;
		logic [1:0] remote_state;
		logic colour_ack_enable;
		logic falling_direction;
		logic extra_threshold_colour_enable;
		logic alarm_colour_enable;
		logic relay2_colour_enable;
		logic relay1_colour_enable;
		logic base_colour_select;
		logic [1:0] dec_point;
		logic [2:0] filter_level;
		logic [1:0] input_range;
		char_t charact;
		crit_t critical_reaction2;
		crit_t critical_reaction1;
		rmode_t mode2;
		rmode_t mode1;
	} ctrl_t;
	typedef struct packed {
		logic signed [15:0] y;
		logic signed [15:0] x;
	} point_t;
	function automatic logic [31:0] full_scale_uv(input logic [1:0] sel);
		logic [31:0] r;
		r = (sel == 2'h0) ? 32'h0000_EA60 : (sel == 2'h1) ? 32'h0001_24F8 :
			(sel == 2'h2) ? 32'h0001_86A0 : 32'h0002_49F0;
		return r;
	endfunction
	function automatic logic in_disp(input logic signed [19:0] v);
		return (v >= DISP_MIN) && (v <= DISP_MAX);
	endfunction
endpackage

// ==== bench/meter_front_model.sv ====
// behavioural front end: measured input, result, relay decisions, frames and keys
`timescale 1ns/100ps
module meter_front_model (
	// clock
	input wire logic clk,
	// levels requested by the bench
	input wire logic signed [19:0] uv_req,
	input wire logic signed [19:0] res_req,
	input wire logic [1:0] raw_req,
	input wire logic [3:0] key_req,
	input wire logic frame_req,
	// towards the meter
	output logic signed [19:0] input_uv,
	output logic signed [19:0] result_value,
	output logic [1:0] relay_raw,
	output logic [3:0] keys,
	output logic frame_rx
);
	initial begin
		input_uv = 20'sh0;
		result_value = 20'sh0;
		relay_raw = 2'h0;
		keys = 4'h0;
		frame_rx = 1'b0;
	end
	// converter results launched just after the edge, as a sampled front end would
	always @(posedge clk) begin
		input_uv <= uv_req;
		result_value <= res_req;
		relay_raw <= raw_req;
		keys <= key_req;
		frame_rx <= frame_req;
	end
endmodule

// ==== bench/tb.sv ====
// self-checking bench: random front-end values plus relay, range and colour corners
`timescale 1ns/100ps
module tb;
	localparam int unsigned TICK = 2;
	logic clk, srst, hsel, hwrite, frame_req, hreadyout, hresp, alarm_out, colour_red, colour_green, red, oor_e;
	logic [31:0] haddr, hwdata, hrdata, rd, s;
	logic [1:0] htrans, raw_req, relay_raw, relay_out;
	logic [2:0] hsize;
	logic [3:0] key_req, keys;
	logic frame_rx;
	logic signed [19:0] uv_req, res_req, input_uv, result_value, uv, r;
	logic signed [15:0] disp_value;
	logic [1:0] dec_point, input_range;
	logic [2:0] filter_level;
	meter_pkg::char_t charact;
	meter_pkg::disp_t disp_sel, e;
	meter_pkg::ctrl_t c;
	int error_cnt, cmp_count, cyc;
	logic signed [19:0] cu [5] = '{20'sd71940, 20'sd71941, -20'sd1, 20'sd30000, 20'sd0};
	logic signed [19:0] cr [5] = '{20'sd9999, 20'sd0, 20'sd0, 20'sd10000, -20'sd1000};
	meter_front_model meter_front_model_inst (.clk, .uv_req, .res_req, .raw_req, .key_req, .frame_req,
		.input_uv, .result_value, .relay_raw, .keys, .frame_rx);
	meter_alarm_scaling_colour_ctrl #(.TICK_CYC(TICK), .MAX_POINTS(20)) meter_alarm_scaling_colour_ctrl_inst (
		.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .input_uv, .result_value, .relay_raw, .frame_rx, .keys, .relay_out,
		.alarm_out, .colour_red, .colour_green, .disp_sel, .disp_value, .dec_point, .filter_level,
		.input_range, .charact);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// 60 mV range; border grows by pct tenths of a percent
	function automatic meter_pkg::disp_t exp_disp(input logic signed [19:0] u, input logic signed [19:0] v, input int pct);
		if (u < 0) return meter_pkg::DS_UNDER;
		if (u * 1000 > 60000 * (1000 + pct)) return meter_pkg::DS_OVER;
		if (v < meter_pkg::DISP_MIN || v > meter_pkg::DISP_MAX) return meter_pkg::DS_OVFL;
		return meter_pkg::DS_NUMBER;
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			$display("[ERR] %s expected %h seen %h", n, x, g);
			error_cnt++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic drive(input logic signed [19:0] u, input logic signed [19:0] v, input logic [1:0] w, input int k);
		uv_req <= u;
		res_req <= v;
		raw_req <= w;
		repeat (k) @(posedge clk);
	endtask
	task automatic press();
		key_req <= 4'h4;
		repeat (6) @(posedge clk);
		key_req <= 4'h0;
		repeat (6) @(posedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard well above the comm-timeout waits
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		{srst, hsel, hwrite, frame_req, htrans, raw_req, hsize, key_req} = '0;
		srst = 1'b1;
		{haddr, hwdata, uv_req, res_req, cyc, error_cnt, cmp_count} = '0;
		s = 32'h2342D4F8;
		red = 1'b0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("relay_out", 0, relay_out);
		chk("colour_green", 1, colour_green);
		c = '0;
		c.mode1 = meter_pkg::RM_ON;
		c.critical_reaction1 = meter_pkg::CR_OFF;
		c.critical_reaction2 = meter_pkg::CR_ON;
		c.alarm_colour_enable = 1'b1;
		c.dec_point = 2'h3;
		c.filter_level = 3'h5;
		c.charact = meter_pkg::CH_SQRT;
		bus(1'b1, meter_pkg::REG_CTRL, c);
		bus(1'b1, meter_pkg::REG_CTRL, c | 32'h0000_8000);
		bus(1'b1, meter_pkg::REG_LIMIT, 32'h0000_00C7);
		bus(1'b1, meter_pkg::REG_LIMIT, 32'h0000_00C8);
		bus(1'b0, meter_pkg::REG_LIMIT, 32'h0);
		chk("limit", 32'h0000_00C7, rd);
		bus(1'b0, meter_pkg::REG_CTRL, 32'h0);
		chk("ctrl", c, rd);
		chk("dec_point", 3, dec_point);
		chk("filter_level", 5, filter_level);
		chk("input_range", 0, input_range);
		chk("charact", meter_pkg::CH_SQRT, charact);
		bus(1'b0, 8'hFC, 32'h0);
		chk("unmapped", 0, rd);
		chk("hresp", 0, hresp);
		// corners first, then random; forced-off relay1, disabled-but-forced-on relay2
		for (int i = 0; i < 40; i++) begin
			s = lfsr(s);
			uv = (i < 5) ? cu[i] : $signed({3'h0, s[16:0]}) - 20'sd10000;
			r = (i < 5) ? cr[i] : $signed({6'h0, s[31:18]}) - 20'sd2000;
			drive(uv, r, s[3:2], 5);
			e = exp_disp(uv, r, 199);
			oor_e = (e == meter_pkg::DS_UNDER) | (e == meter_pkg::DS_OVER);
			red = red | oor_e;
			chk("disp_sel", e, disp_sel);
			chk("alarm_out", oor_e, alarm_out);
			chk("relay_out", oor_e ? 2'h2 : {1'b0, s[2]}, relay_out);
			if (e == meter_pkg::DS_NUMBER) chk("disp_value", r, disp_value);
			chk("colour_red", red, colour_red);
		end
		press();
		chk("colour_red", 1, colour_red);
		c.colour_ack_enable = 1'b1;
		c.critical_reaction1 = meter_pkg::CR_KEEP;
		bus(1'b1, meter_pkg::REG_CTRL, c);
		drive(20'sd1000, 20'sd5, 2'h1, 5);
		press();
		chk("colour_green", 1, colour_green);
		chk("relay_out", 1, relay_out);
		drive(-20'sd50, 20'sd5, 2'h0, 5);
		chk("relay_out", 3, relay_out);
		// remote relay on, dropped once two whole seconds pass without frames (timeout 1)
		c.mode1 = meter_pkg::RM_REMOTE;
		c.remote_state = 2'h1;
		c.critical_reaction1 = meter_pkg::CR_OFF;
		c.critical_reaction2 = meter_pkg::CR_KEEP;
		bus(1'b1, meter_pkg::REG_CTRL, c);
		bus(1'b1, meter_pkg::REG_LIMIT, 32'h0000_01C7);
		drive(20'sd1000, 20'sd5, 2'h0, 1);
		frame_req <= 1'b1;
		drive(20'sd1000, 20'sd5, 2'h0, 1);
		frame_req <= 1'b0;
		drive(20'sd1000, 20'sd5, 2'h0, 2200);
		chk("relay_out", 1, relay_out);
		drive(20'sd1000, 20'sd5, 2'h0, 4300);
		chk("relay_out", 0, relay_out);
		bus(1'b1, meter_pkg::REG_LIMIT, 32'h0000_00C7);
		drive(20'sd1000, 20'sd5, 2'h0, 6500);
		chk("relay_out", 1, relay_out);
		// colour threshold 100, hysteresis 10, rising direction
		bus(1'b1, meter_pkg::REG_COLTH, 32'h000A_0064);
		c.extra_threshold_colour_enable = 1'b1;
		bus(1'b1, meter_pkg::REG_CTRL, c);
		drive(20'sd1000, 20'sd50, 2'h0, 5);
		press();
		drive(20'sd1000, 20'sd105, 2'h0, 5);
		chk("colour_red", 0, colour_red);
		drive(20'sd1000, 20'sd111, 2'h0, 5);
		chk("colour_red", 1, colour_red);
		// user curve: blocked scale write, three points, duplicate rejected
		c.charact = meter_pkg::CH_USER;
		bus(1'b1, meter_pkg::REG_CTRL, c);
		bus(1'b1, meter_pkg::REG_SCALE, 32'h0064_0000);
		bus(1'b1, meter_pkg::REG_POINT, 32'h0BB8_0000);
		bus(1'b1, meter_pkg::REG_CMD, 32'h1);
		drive(20'sd1000, 20'sd5, 2'h0, 5);
		chk("disp_sel", meter_pkg::DS_FEW, disp_sel);
		bus(1'b1, meter_pkg::REG_POINT, 32'hFC19_03E8);
		bus(1'b1, meter_pkg::REG_CMD, 32'h1);
		bus(1'b1, meter_pkg::REG_POINT, 32'h0007_01F4);
		bus(1'b1, meter_pkg::REG_CMD, 32'h1);
		bus(1'b1, meter_pkg::REG_POINT, 32'h0BB8_0000);
		bus(1'b1, meter_pkg::REG_CMD, 32'h1);
		bus(1'b0, meter_pkg::REG_STAT, 32'h0);
		chk("point_cnt", 3, rd[4:0]);
		chk("point_err", 1, rd[5]);
		bus(1'b0, meter_pkg::REG_SCALE, 32'h0);
		chk("curve_scale", 32'hFC19_0BB8, rd);
		chk("disp_sel", meter_pkg::DS_ERR, disp_sel);
		// delete browse: count, long enter, confirm
		bus(1'b1, meter_pkg::REG_CMD, 32'h2);
		drive(20'sd1000, 20'sd5, 2'h0, 3100);
		key_req <= 4'h4;
		drive(20'sd1000, 20'sd5, 2'h0, 4100);
		key_req <= 4'h0;
		drive(20'sd1000, 20'sd5, 2'h0, 10);
		chk("disp_sel", meter_pkg::DS_ASK, disp_sel);
		press();
		chk("disp_sel", meter_pkg::DS_COUNT, disp_sel);
		chk("disp_value", 2, disp_value);
		test_done();
	end
endmodule
